/* ranging_result_pkg.sv */
// Package with register indices, field positions, reset values and helpers for the result bank.
package ranging_result_pkg;

	// ==========================================================================
	// Widths
	// ==========================================================================
	localparam int unsigned APB_ADDR_W = 8;
	localparam int unsigned APB_DATA_W = 32;
	localparam int unsigned COUNT_W    = 32;
	localparam int unsigned XTALK_W    = 16;

	typedef logic [7:0] reg_index_t;

	// ==========================================================================
	// Register indices; the byte address on the bus is four times the index
	// ==========================================================================
	localparam reg_index_t IDX_REF_COUNT_BYTE1          = 8'h35;
	localparam reg_index_t IDX_REF_COUNT_BYTE2          = 8'h36;
	localparam reg_index_t IDX_REF_COUNT_BYTE3          = 8'h37;
	localparam reg_index_t IDX_TARGET_COUNT_BYTE0       = 8'h38;
	localparam reg_index_t IDX_TARGET_COUNT_BYTE1       = 8'h39;
	localparam reg_index_t IDX_TARGET_COUNT_BYTE2       = 8'h3a;
	localparam reg_index_t IDX_TARGET_COUNT_BYTE3       = 8'h3b;
	localparam reg_index_t IDX_CROSSTALK_PEAK_HIGH_BYTE = 8'h3c;
	localparam reg_index_t IDX_CROSSTALK_PEAK_LOW_BYTE  = 8'h3d;
	localparam reg_index_t IDX_RESULT_STATUS            = 8'h3e;
	localparam reg_index_t IDX_CAPTURE_CONTROL          = 8'h3f;

	// ==========================================================================
	// Field positions
	// ==========================================================================
	localparam int unsigned STATUS_RESULT_SEEN_BIT = 0;
	localparam int unsigned STATUS_TARGET_BIT      = 1;
	localparam int unsigned STATUS_ALGO_BIT        = 2;
	localparam int unsigned CTRL_CAPTURE_EN_BIT    = 0;

	// ==========================================================================
	// Reset values
	// ==========================================================================
	localparam logic [COUNT_W-1:0] RST_COUNT      = 32'h0000_0000;
	localparam logic [XTALK_W-1:0] RST_XTALK      = 16'h0000;
	localparam logic               RST_CAPTURE_EN = 1'b1;
	localparam logic               RST_FLAG       = 1'b0;

	// ==========================================================================
	// Helpers
	// ==========================================================================
	// Byte address of a register index; all indices stay below 8'h40.
	function automatic logic [APB_ADDR_W-1:0] byte_addr(input reg_index_t idx);
		return {idx[5:0], 2'b00};
	endfunction

	// One byte lane of a word, lane 0 being the least significant.
	function automatic logic [7:0] byte_of(input logic [31:0] w, input logic [1:0] lane);
		logic [7:0] b;
		case (lane)
			2'd0: b = w[7:0];
			2'd1: b = w[15:8];
			2'd2: b = w[23:16];
			default: b = w[31:24];
		endcase
		return b;
	endfunction

endpackage

/* apb_read_stage.sv */
// APB response stage: registers read data and error in the setup cycle, answers in the access.
`timescale 1ns/1ps

module apb_read_stage
	import ranging_result_pkg::*;
(
	input  wire logic                  core_clk_in,
	input  wire logic                  rst_in,
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic [7:0]            rd_byte_in,
	input  wire logic                  addr_hit_in,
	output logic      [APB_DATA_W-1:0] prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out
);

	logic setup_phase;
	logic err_q;

	// Setup cycle of a transfer; the only cycle in which the answer is sampled.
	assign setup_phase = psel_in & ~penable_in;

	// Read data is taken from flip-flops so the bus never sees a combinational mux path.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (setup_phase) begin
			prdata_out <= {24'h00_0000, rd_byte_in};
		end
	end

	// Error flag for an unmapped or misaligned address, held for the access phase.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			err_q <= 1'b0;
		end else if (setup_phase) begin
			err_q <= ~addr_hit_in;
		end
	end

	// Zero wait states: every access phase completes in its first cycle.
	assign pready_out  = psel_in & penable_in;
	assign pslverr_out = psel_in & penable_in & err_q;

endmodule // apb_read_stage

/* ranging_result_bank.sv */
// Result register bank of the ranging sensor: hit counts and crosstalk peak behind APB.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

module ranging_result_bank
	import ranging_result_pkg::*;
(
	input  wire logic                  core_clk_in,
	input  wire logic                  rst_in,
	// APB slave.
	input  wire logic                  psel_in,
	input  wire logic                  penable_in,
	input  wire logic                  pwrite_in,
	input  wire logic [APB_ADDR_W-1:0] paddr_in,
	input  wire logic [APB_DATA_W-1:0] pwdata_in,
	input  wire logic [3:0]            pstrb_in,
	output logic      [APB_DATA_W-1:0] prdata_out,
	output logic                       pready_out,
	output logic                       pslverr_out,
	// Measurement engine.
	input  wire logic                  result_valid_in,
	input  wire logic                  target_detected_in,
	input  wire logic                  distance_algo_used_in,
	input  wire logic [COUNT_W-1:0]    ref_count_in,
	input  wire logic [COUNT_W-1:0]    target_count_in,
	input  wire logic [XTALK_W-1:0]    crosstalk_peak_in
);

	// ==========================================================================
	// Declarations
	// ==========================================================================
	logic [COUNT_W-1:0] ref_count_q;
	logic [COUNT_W-1:0] target_count_q;
	logic [XTALK_W-1:0] crosstalk_peak_q;
	logic               capture_en_q;
	logic               result_seen_q;
	logic               target_flag_q;
	logic               algo_flag_q;
	logic               capture;
	logic               counts_valid;
	logic               ctrl_write;
	logic [7:0]         rd_byte;
	logic               addr_hit;
	logic [7:0]         status_byte;

	// ==========================================================================
	// Capture of a finished measurement
	// ==========================================================================
	// A result is taken only while capture is enabled, so software can freeze the
	// bank and read a multi-byte count without tearing it across two measurements.
	assign capture      = result_valid_in & capture_en_q;
	// Counts only carry meaning when the distance algorithm found a target.
	assign counts_valid = target_detected_in & distance_algo_used_in;

	// Reference count snapshot; forced to zero when no target or algorithm.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			ref_count_q <= RST_COUNT;
		end else if (capture) begin
			ref_count_q <= counts_valid ? ref_count_in : RST_COUNT;
		end
	end

	// Target count snapshot; forced to zero when no target or algorithm.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			target_count_q <= RST_COUNT;
		end else if (capture) begin
			target_count_q <= counts_valid ? target_count_in : RST_COUNT;
		end
	end

	// Crosstalk peak snapshot; its validity depends on scene conditions the host
	// must arrange, so it is stored whatever the target flag says.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			crosstalk_peak_q <= RST_XTALK;
		end else if (capture) begin
			crosstalk_peak_q <= crosstalk_peak_in;
		end
	end

	// Status flags describing the stored measurement.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			result_seen_q <= RST_FLAG;
			target_flag_q <= RST_FLAG;
			algo_flag_q   <= RST_FLAG;
		end else if (capture) begin
			result_seen_q <= 1'b1;
			target_flag_q <= target_detected_in;
			algo_flag_q   <= distance_algo_used_in;
		end
	end

	// ==========================================================================
	// Control register
	// ==========================================================================
	// A write takes effect in the access phase only; writes to the result bytes
	// match no decode here and so leave the bank untouched.
	assign ctrl_write = psel_in & penable_in & pwrite_in & pstrb_in[0]
		& (paddr_in == byte_addr(IDX_CAPTURE_CONTROL));

	// Capture enable, set after reset so results flow without software help.
	always_ff @(posedge core_clk_in or posedge rst_in) begin
		if (rst_in) begin
			capture_en_q <= RST_CAPTURE_EN;
		end else if (ctrl_write) begin
			capture_en_q <= pwdata_in[CTRL_CAPTURE_EN_BIT];
		end
	end

	// ==========================================================================
	// Read decode
	// ==========================================================================
	// Status byte with unused bits reading as zero.
	always_comb begin
		status_byte = 8'h00;
		status_byte[STATUS_RESULT_SEEN_BIT] = result_seen_q;
		status_byte[STATUS_TARGET_BIT]      = target_flag_q;
		status_byte[STATUS_ALGO_BIT]        = algo_flag_q;
	end

	// Byte selection by address; unmapped addresses read zero and flag an error.
	always_comb begin
		rd_byte  = 8'h00;
		addr_hit = 1'b1;
		case (paddr_in)
			byte_addr(IDX_REF_COUNT_BYTE1):    rd_byte = byte_of(ref_count_q, 2'd1);
			byte_addr(IDX_REF_COUNT_BYTE2):    rd_byte = byte_of(ref_count_q, 2'd2);
			byte_addr(IDX_REF_COUNT_BYTE3):    rd_byte = byte_of(ref_count_q, 2'd3);
			byte_addr(IDX_TARGET_COUNT_BYTE0): rd_byte = byte_of(target_count_q, 2'd0);
			byte_addr(IDX_TARGET_COUNT_BYTE1): rd_byte = byte_of(target_count_q, 2'd1);
			byte_addr(IDX_TARGET_COUNT_BYTE2): rd_byte = byte_of(target_count_q, 2'd2);
			byte_addr(IDX_TARGET_COUNT_BYTE3): rd_byte = byte_of(target_count_q, 2'd3);
			byte_addr(IDX_CROSSTALK_PEAK_HIGH_BYTE): begin
				rd_byte = crosstalk_peak_q[15:8];
			end
			byte_addr(IDX_CROSSTALK_PEAK_LOW_BYTE): begin
				rd_byte = crosstalk_peak_q[7:0];
			end
			byte_addr(IDX_RESULT_STATUS):      rd_byte = status_byte;
			byte_addr(IDX_CAPTURE_CONTROL):    rd_byte = {7'h00, capture_en_q};
			default:                           addr_hit = 1'b0;
		endcase
	end

	// ==========================================================================
	// Bus response
	// ==========================================================================
	apb_read_stage u_read_stage (
		.core_clk_in (core_clk_in),
		.rst_in      (rst_in),
		.psel_in     (psel_in),
		.penable_in  (penable_in),
		.rd_byte_in  (rd_byte),
		.addr_hit_in (addr_hit),
		.prdata_out  (prdata_out),
		.pready_out  (pready_out),
		.pslverr_out (pslverr_out)
	);

	// ==========================================================================
	// Assertions
	// ==========================================================================
	default clocking cb @(posedge core_clk_in);
	endclocking
	default disable iff (rst_in);

	// A read setup at a given address, named so several checks share it.
	sequence read_setup_at(logic [APB_ADDR_W-1:0] a);
		psel_in && !penable_in && !pwrite_in && paddr_in == a;
	endsequence

	// Capture checks. The counts are gated by the target and algorithm flags,
	// while the crosstalk peak is stored on every capture, because its own
	// validity depends on scene conditions that only the host can arrange.
	a_ref_zero_gate: assert property (
		capture && !counts_valid
		|=> ref_count_q == 32'h0000_0000)
		else $error("reference count not zeroed without target");

	a_target_zero_gate: assert property (
		capture && !(target_detected_in && distance_algo_used_in)
		|=> target_count_q == 32'h0000_0000)
		else $error("target count not zeroed without target");

	a_ref_count_take: assert property (
		capture && counts_valid
		|=> ref_count_q == $past(ref_count_in))
		else $error("reference count not taken from valid result");

	a_target_count_take: assert property (
		capture && counts_valid
		|=> target_count_q == $past(target_count_in))
		else $error("target count not taken from valid result");

	a_xtalk_take: assert property (
		capture
		|=> crosstalk_peak_q == $past(crosstalk_peak_in))
		else $error("crosstalk peak not taken");

	// The status flags describe the same capture that filled the counts.
	a_status_take: assert property (
		capture |=> result_seen_q
		&& target_flag_q == $past(target_detected_in)
		&& algo_flag_q == $past(distance_algo_used_in))
		else $error("status flags not taken with the result");

	// Hold checks. Only a capture may move a result; a bus write never does.
	// A cleared capture enable keeps the bank frozen, which is what lets
	// software read a multi-byte count without tearing it.
	a_counts_hold: assert property (
		!capture |=> $stable(ref_count_q) && $stable(target_count_q)
		&& $stable(crosstalk_peak_q))
		else $error("result changed without a capture");

	a_write_no_effect: assert property (
		psel_in && penable_in && pwrite_in && !result_valid_in
		|=> $stable(ref_count_q) && $stable(target_count_q) && $stable(crosstalk_peak_q))
		else $error("write altered a result register");

	a_frozen_hold: assert property (
		!capture_en_q [*3]
		|-> $stable(ref_count_q) && $stable(target_count_q))
		else $error("results changed while capture disabled");

	a_ctrl_write_take: assert property (
		ctrl_write
		|=> capture_en_q == $past(pwdata_in[CTRL_CAPTURE_EN_BIT]))
		else $error("capture enable not taken from write");

	// Read checks. Read data is registered in the setup cycle, so the access
	// phase must show the byte that the bank held at that setup edge; a capture
	// in the same cycle is seen only by the next read.
	a_ref_byte1_read: assert property (
		read_setup_at(byte_addr(IDX_REF_COUNT_BYTE1)) ##1 penable_in
		|-> prdata_out == {24'h00_0000, $past(ref_count_q[15:8])})
		else $error("reference byte 1 read wrong");

	a_ref_byte_read: assert property (
		read_setup_at(byte_addr(IDX_REF_COUNT_BYTE2)) ##1 penable_in
		|-> pready_out && prdata_out == {24'h00_0000, $past(ref_count_q[23:16])})
		else $error("reference byte 2 read wrong");

	a_ref_byte3_read: assert property (
		read_setup_at(byte_addr(IDX_REF_COUNT_BYTE3)) ##1 penable_in
		|-> prdata_out == {24'h00_0000, $past(ref_count_q[31:24])})
		else $error("reference byte 3 read wrong");

	a_target_byte_read: assert property (
		read_setup_at(byte_addr(IDX_TARGET_COUNT_BYTE0)) ##1 penable_in
		|-> prdata_out == {24'h00_0000, $past(target_count_q[7:0])})
		else $error("target byte 0 read wrong");

	a_target_byte1_read: assert property (
		read_setup_at(byte_addr(IDX_TARGET_COUNT_BYTE1)) ##1 penable_in
		|-> prdata_out == {24'h00_0000, $past(target_count_q[15:8])})
		else $error("target byte 1 read wrong");

	a_target_byte2_read: assert property (
		read_setup_at(byte_addr(IDX_TARGET_COUNT_BYTE2)) ##1 penable_in
		|-> prdata_out == {24'h00_0000, $past(target_count_q[23:16])})
		else $error("target byte 2 read wrong");

	a_target_byte3_read: assert property (
		read_setup_at(byte_addr(IDX_TARGET_COUNT_BYTE3)) ##1 penable_in
		|-> prdata_out == {24'h00_0000, $past(target_count_q[31:24])})
		else $error("target byte 3 read wrong");

	a_xtalk_high_read: assert property (
		read_setup_at(byte_addr(IDX_CROSSTALK_PEAK_HIGH_BYTE)) ##1 penable_in
		|-> prdata_out == {24'h00_0000, $past(crosstalk_peak_q[15:8])})
		else $error("crosstalk high byte read wrong");

	a_xtalk_low_read: assert property (
		read_setup_at(byte_addr(IDX_CROSSTALK_PEAK_LOW_BYTE)) ##1 penable_in
		|-> prdata_out == {24'h00_0000, $past(crosstalk_peak_q[7:0])})
		else $error("crosstalk low byte read wrong");

	// Bus checks. Every access phase ends in its first cycle, and an error is
	// raised only for an address outside the map; a write to a read-only byte
	// is dropped quietly so that a driver probing the bank does not trip.
	a_ready_access: assert property (
		psel_in && penable_in
		|-> pready_out)
		else $error("access phase not answered at once");

	a_unmapped_err: assert property (
		psel_in && !penable_in && !addr_hit ##1 penable_in
		|-> pslverr_out && pready_out)
		else $error("unmapped access not flagged");

	a_ro_write_ok: assert property (
		psel_in && !penable_in && pwrite_in && addr_hit ##1 penable_in
		|-> pready_out && !pslverr_out)
		else $error("write to a mapped byte flagged as error");

	// Scenarios worth seeing: a valid result read back, a gated result, a
	// frozen bank refusing a result, a bus error and a write to a result byte.
	cover_target_read: cover property (
		capture && counts_valid ##[1:20] read_setup_at(byte_addr(IDX_TARGET_COUNT_BYTE3)));
	cover_no_target: cover property (capture && !counts_valid);
	cover_freeze: cover property (ctrl_write && !pwdata_in[CTRL_CAPTURE_EN_BIT]
		##[1:50] result_valid_in);
	cover_unmapped: cover property (pslverr_out);
	cover_ro_write: cover property (
		psel_in && penable_in && pwrite_in && !pslverr_out && !ctrl_write);

endmodule // ranging_result_bank

/* ranging_result_bank_test.sv */
// Self-checking testbench for the ranging result register bank.
`timescale 1ns/1ps

`define CHECK(got, exp) begin \
	samples_checked++; \
	if ((got) !== (exp)) begin \
		n_errors++; \
		$display("ERROR at %0t: got %h expected %h", $time, got, exp); \
	end \
end

module ranging_result_bank_test
	import ranging_result_pkg::*;
;
	// ==========================================================================
	// Signals
	// ==========================================================================
	logic                  core_clk_in;
	logic                  rst_in;
	logic                  psel_in;
	logic                  penable_in;
	logic                  pwrite_in;
	logic [APB_ADDR_W-1:0] paddr_in;
	logic [APB_DATA_W-1:0] pwdata_in;
	logic [3:0]            pstrb_in;
	logic [APB_DATA_W-1:0] prdata_out;
	logic                  pready_out;
	logic                  pslverr_out;
	logic                  result_valid_in;
	logic                  target_detected_in;
	logic                  distance_algo_used_in;
	logic [COUNT_W-1:0]    ref_count_in;
	logic [COUNT_W-1:0]    target_count_in;
	logic [XTALK_W-1:0]    crosstalk_peak_in;
	logic [32:0]           exp_q[$];
	int                    n_errors;
	int                    samples_checked;
	int                    seed;

	// ==========================================================================
	// Design under test
	// ==========================================================================
	ranging_result_bank uut (
		.core_clk_in(core_clk_in), .rst_in(rst_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .pstrb_in(pstrb_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out),
		.result_valid_in(result_valid_in), .target_detected_in(target_detected_in),
		.distance_algo_used_in(distance_algo_used_in), .ref_count_in(ref_count_in),
		.target_count_in(target_count_in), .crosstalk_peak_in(crosstalk_peak_in)
	);

	// 40 MHz clock.
	initial begin
		core_clk_in = 1'b0;
		forever #12.5 core_clk_in = ~core_clk_in;
	end

	// ==========================================================================
	// Tasks
	// ==========================================================================
	// Prints the counts and the verdict, then ends the run.
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	// One APB transfer; a read notes its expected {error, data} for the monitor.
	task automatic apb_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
			input logic [32:0] exp);
		int n;
		@(posedge core_clk_in);
		psel_in    <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in  <= wr;
		paddr_in   <= a;
		pwdata_in  <= d;
		pstrb_in   <= 4'hf;
		if (!wr) begin
			exp_q.push_back(exp);
		end
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk_in);
			n++;
		end while (pready_out !== 1'b1 && n < 20);
		if (n >= 20) begin
			n_errors++;
			final_report();
		end else begin
			psel_in    <= 1'b0;
			penable_in <= 1'b0;
			pwrite_in  <= 1'b0;
		end
	endtask

	// Reads one byte register; the byte address is four times its index.
	task automatic read_reg(input reg_index_t idx, input logic [7:0] b);
		apb_xfer(1'b0, {idx[5:0], 2'b00}, 32'h0000_0000, {1'b0, 24'h00_0000, b});
	endtask

	// Reads the count and crosstalk bytes of the bank against the values that software should assemble.
	task automatic check_bank(input logic [31:0] r, input logic [31:0] t, input logic [15:0] x);
		read_reg(IDX_REF_COUNT_BYTE1, r[15:8]);
		read_reg(IDX_REF_COUNT_BYTE2, r[23:16]);
		read_reg(IDX_REF_COUNT_BYTE3, r[31:24]);
		read_reg(IDX_TARGET_COUNT_BYTE0, t[7:0]);
		read_reg(IDX_TARGET_COUNT_BYTE1, t[15:8]);
		read_reg(IDX_TARGET_COUNT_BYTE2, t[23:16]);
		read_reg(IDX_TARGET_COUNT_BYTE3, t[31:24]);
		read_reg(IDX_CROSSTALK_PEAK_HIGH_BYTE, x[15:8]);
		read_reg(IDX_CROSSTALK_PEAK_LOW_BYTE, x[7:0]);
	endtask

	// One measurement pulse, then fresh noise on the inputs so a late sample shows up.
	task automatic measure(input logic tgt, input logic alg, input logic [31:0] r,
			input logic [31:0] t, input logic [15:0] x);
		@(posedge core_clk_in);
		result_valid_in       <= 1'b1;
		target_detected_in    <= tgt;
		distance_algo_used_in <= alg;
		ref_count_in          <= r;
		target_count_in       <= t;
		crosstalk_peak_in     <= x;
		@(posedge core_clk_in);
		result_valid_in       <= 1'b0;
		target_detected_in    <= ~tgt;
		distance_algo_used_in <= ~alg;
		ref_count_in          <= $random(seed);
		target_count_in       <= $random(seed);
		crosstalk_peak_in     <= 16'($random(seed));
	endtask

	// ==========================================================================
	// Monitor: every completed read takes the oldest note off the queue.
	// ==========================================================================
	always @(posedge core_clk_in) begin
		logic [32:0] exp_v;
		if (psel_in && penable_in && pready_out === 1'b1 && !pwrite_in) begin
			exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 33'h1_ffff_ffff;
			`CHECK({pslverr_out, prdata_out}, exp_v)
		end
	end

	// ==========================================================================
	// Main sequence
	// ==========================================================================
	initial begin
		logic [31:0] r;
		logic [31:0] t;
		logic [15:0] x;
		logic        both;
		seed = 38322;
		n_errors = 0;
		samples_checked = 0;
		rst_in = 1'b1;
		{psel_in, penable_in, pwrite_in, result_valid_in} = 4'h0;
		{target_detected_in, distance_algo_used_in} = 2'b00;
		paddr_in = 8'h00;
		pwdata_in = 32'h0000_0000;
		pstrb_in = 4'h0;
		ref_count_in = 32'h0000_0000;
		target_count_in = 32'h0000_0000;
		crosstalk_peak_in = 16'h0000;
		repeat (6) @(posedge core_clk_in);
		rst_in <= 1'b0;
		check_bank(32'h0, 32'h0, 16'h0);
		// Software writes to the result bytes must not stick.
		for (int i = 'h35; i <= 'h3d; i++) begin
			apb_xfer(1'b1, 8'(i * 4), $random(seed), 33'h0);
		end
		check_bank(32'h0, 32'h0, 16'h0);
		// Unmapped and misaligned addresses answer with an error and zero data.
		apb_xfer(1'b0, 8'h00, 32'h0, {1'b1, 32'h0});
		apb_xfer(1'b0, 8'hd5, 32'h0, {1'b1, 32'h0});
		// Every flag combination twice, random counts; only both flags keep counts.
		for (int k = 0; k < 8; k++) begin
			r = $random(seed);
			t = $random(seed);
			x = 16'($random(seed));
			both = k[1] & k[0];
			measure(k[1], k[0], r, t, x);
			check_bank(both ? r : 32'h0, both ? t : 32'h0, x);
			// Status: bit 0 result seen, bit 1 target flag, bit 2 algorithm flag.
			read_reg(IDX_RESULT_STATUS, {5'h00, k[0], k[1], 1'b1});
		end
		// Frozen bank: a result offered while capture is disabled is refused.
		apb_xfer(1'b1, {IDX_CAPTURE_CONTROL[5:0], 2'b00}, 32'h0000_0000, 33'h0);
		read_reg(IDX_CAPTURE_CONTROL, 8'h00);
		measure(1'b0, 1'b0, ~r, ~t, ~x);
		check_bank(r, t, x);
		read_reg(IDX_RESULT_STATUS, 8'h07);
		// A reset in mid-run clears the bank and enables capture again.
		rst_in <= 1'b1;
		repeat (2) @(posedge core_clk_in);
		rst_in <= 1'b0;
		check_bank(32'h0, 32'h0, 16'h0);
		read_reg(IDX_RESULT_STATUS, 8'h00);
		read_reg(IDX_CAPTURE_CONTROL, {7'h00, RST_CAPTURE_EN});
		repeat (4) @(posedge core_clk_in);
		if (exp_q.size() != 0) begin
			n_errors++;
		end
		final_report();
	end

endmodule // ranging_result_bank_test
